// ### common/sarrd_params.svh
`ifndef SARRD_PARAMS_SVH
`define SARRD_PARAMS_SVH

// Clock and conversion timing
`define SARRD_CLK_PERIOD_PS 20000
`define SARRD_CONV_TIME_NS 322
`define SARRD_CONV_CYCLES ((`SARRD_CONV_TIME_NS * 1000) / `SARRD_CLK_PERIOD_PS)
`define SARRD_CNT_W 5

// Result word
`define SARRD_RES_W 16
`define SARRD_SQUEEZE_GAIN 17'h06666

// Register byte offsets
`define SARRD_OFF_CTRL 8'h00
`define SARRD_OFF_STATUS 8'h04
`define SARRD_OFF_SAMPLE 8'h08
`define SARRD_OFF_RESULT 8'h0C
`define SARRD_OFF_COUNT 8'h10

// Control fields and reset values
`define SARRD_CTRL_CONV_EN 0
`define SARRD_CTRL_RESET 32'h00000001
`define SARRD_SAMPLE_RESET 16'h0000

// Status fields
`define SARRD_ST_BUSY 0
`define SARRD_ST_CHAIN 1
`define SARRD_ST_SQUEEZE 2
`define SARRD_ST_OUT_EN 3

// Bus responses
`define SARRD_RESP_OKAY 2'h0
`define SARRD_RESP_SLVERR 2'h2

`endif

// ### common/sarrd_pkg.sv
package sarrd_pkg;

   // Pins arriving from outside the clock domain
   typedef struct packed {
      logic convert_start;
      logic shift_clock;
      logic chain_select;
      logic read_enable_or_upstream_input;
      logic gain_compression_select;
   } sarrd_pins_t;

   // Conversion sequencer states
   typedef enum logic [0:0] {
      SARRD_POWER_DOWN,
      SARRD_CONVERTING
   } sarrd_state_t;

endpackage : sarrd_pkg

// ### hdl/sarrd_pin_sync.sv
`timescale 1ns/1ps
module sarrd_pin_sync #(
   parameter int WIDTH = 5
) (
   input wire logic aclk, // System clock
   input wire logic aresetn, // Synchronous reset, active low
   input wire logic [WIDTH-1:0] d, // Asynchronous pin levels
   output logic [WIDTH-1:0] q, // Synchronised levels
   output logic [WIDTH-1:0] rise // One-cycle rising-edge pulses
);
   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] sync_q;
   logic [WIDTH-1:0] last_q;

   // Two flip-flops per bit, then a delay stage for edges
   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : g_bit
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               meta_q[i] <= 1'b0;
               sync_q[i] <= 1'b0;
               last_q[i] <= 1'b0;
            end else begin
               meta_q[i] <= d[i];
               sync_q[i] <= meta_q[i];
               last_q[i] <= sync_q[i];
            end
         end
         assign rise[i] = sync_q[i] & ~last_q[i];
      end
   endgenerate

   assign q = sync_q;
endmodule : sarrd_pin_sync

// ### hdl/sarrd_top.sv
// Summary of operation
// - Chain select low: normal mode, shared pin gates the serial output.
// - Chain select high: chain mode, shared pin is upstream serial data.
// - Convert-start rising edge wakes device and begins a conversion.
// - Busy rises at conversion start and falls when it completes.
// - Enabled output advances one bit per shift-clock rise, MSB first.
// - Result is two's complement; just above/below zero read 0000/FFFF.
// - Chain mode: after own result, pass upstream data to the output.
// - Chain mode samples upstream input on shift-clock rising edges.
// - Normal mode: drive output after gate falls, release after it rises.
// - Squeeze select high: full range; low: scale into 10%..90% range.
// - Each conversion end prepares a sixteen-bit result word.
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "sarrd_params.svh"
module sarrd_top (
   input wire logic aclk, // System clock, 50 MHz
   input wire logic aresetn, // Synchronous reset, active low
   input wire sarrd_pkg::sarrd_pins_t pins, // Asynchronous device pins
   output logic busy, // Conversion in progress
   output logic result_bit_output, // Serial data out
   output logic result_bit_output_oe, // Serial output driven when high
   input wire logic [31:0] s_axi_awaddr, // Write address
   input wire logic s_axi_awvalid, // Write address valid
   output logic s_axi_awready, // Write address ready
   input wire logic [31:0] s_axi_wdata, // Write data
   input wire logic [3:0] s_axi_wstrb, // Write byte strobes
   input wire logic s_axi_wvalid, // Write data valid
   output logic s_axi_wready, // Write data ready
   output logic [1:0] s_axi_bresp, // Write response
   output logic s_axi_bvalid, // Write response valid
   input wire logic s_axi_bready, // Write response ready
   input wire logic [31:0] s_axi_araddr, // Read address
   input wire logic s_axi_arvalid, // Read address valid
   output logic s_axi_arready, // Read address ready
   output logic [31:0] s_axi_rdata, // Read data
   output logic [1:0] s_axi_rresp, // Read response
   output logic s_axi_rvalid, // Read data valid
   input wire logic s_axi_rready // Read data ready
);
   import sarrd_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisation

   sarrd_pins_t pins_q;
   sarrd_pins_t pins_rise;

   sarrd_pin_sync #(
      .WIDTH($bits(sarrd_pins_t))
   ) u_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .d(pins),
      .q(pins_q),
      .rise(pins_rise)
   );

   ////////////////////////////////////////////////////////////////////////
   // Settling after reset

   logic [2:0] settle_q;
   logic pins_valid;

   // Sync and edge stages refill before pin levels are trusted
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         settle_q <= 3'h0;
      end else begin
         settle_q <= {settle_q[1:0], 1'b1};
      end
   end

   // Reset levels of the sync stages differ from idle pin levels
   assign pins_valid = settle_q[2];

   logic chain_mode;
   logic squeeze_on;
   logic gate_low;
   logic upstream_bit_input;
   logic start_edge;
   logic shift_edge;

   // Shared pin meaning follows the mode
   assign chain_mode = pins_q.chain_select;
   assign gate_low = pins_q.read_enable_or_upstream_input;
   assign upstream_bit_input = pins_q.read_enable_or_upstream_input;
   assign squeeze_on = ~pins_q.gain_compression_select;
   assign start_edge = pins_rise.convert_start & pins_valid;
   assign shift_edge = pins_rise.shift_clock & pins_valid;

   ////////////////////////////////////////////////////////////////////////
   // Software registers

   logic [31:0] ctrl_q;
   logic [`SARRD_RES_W-1:0] sample_q;
   logic [`SARRD_RES_W-1:0] result_q;
   logic [31:0] count_q;

   ////////////////////////////////////////////////////////////////////////
   // Conversion sequencer

   sarrd_state_t state_q;
   logic [`SARRD_CNT_W-1:0] conv_cnt_q;
   logic conv_done;

   assign conv_done = (state_q == SARRD_CONVERTING) &&
      (conv_cnt_q == `SARRD_CNT_W'(`SARRD_CONV_CYCLES - 1));

   // Power-down until a start edge, then count the conversion time
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_q <= SARRD_POWER_DOWN;
         conv_cnt_q <= '0;
      end else begin
         case (state_q)
            SARRD_POWER_DOWN: begin
               if (start_edge && ctrl_q[`SARRD_CTRL_CONV_EN]) begin
                  state_q <= SARRD_CONVERTING;
                  conv_cnt_q <= '0;
               end
            end
            SARRD_CONVERTING: begin
               if (conv_done) begin
                  state_q <= SARRD_POWER_DOWN;
               end else begin
                  conv_cnt_q <= conv_cnt_q + `SARRD_CNT_W'(1);
               end
            end
            default: begin
               state_q <= SARRD_POWER_DOWN;
            end
         endcase
      end
   end

   // Busy output
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         busy <= 1'b0;
      end else if (state_q == SARRD_POWER_DOWN && start_edge &&
                   ctrl_q[`SARRD_CTRL_CONV_EN]) begin
         busy <= 1'b1;
      end else if (conv_done) begin
         busy <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Result coding

   logic signed [32:0] squeeze_prod;
   logic [`SARRD_RES_W-1:0] coded;

   // Squeeze scales by 0.8 so full scale spans 10%..90% of the range
   assign squeeze_prod = $signed(sample_q) *
      $signed(`SARRD_SQUEEZE_GAIN);
   always_comb begin
      if (squeeze_on) begin
         coded = squeeze_prod[30:15];
      end else begin
         coded = sample_q;
      end
   end

   // Latch the two's complement word at conversion end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         result_q <= '0;
         count_q <= '0;
      end else if (conv_done) begin
         result_q <= coded;
         count_q <= count_q + 32'h00000001;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Serial output shifter

   logic [`SARRD_RES_W-1:0] shift_q;
   logic [`SARRD_RES_W-1:0] shift_next;
   logic out_enabled;

   assign out_enabled = chain_mode | ~gate_low;
   // Chain mode refills from upstream, normal mode with zeros
   assign shift_next = {shift_q[`SARRD_RES_W-2:0],
                        chain_mode & upstream_bit_input};

   // Load at busy fall, then advance on each shift-clock rise while the output is enabled
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         shift_q <= '0;
         result_bit_output <= 1'b0;
      end else if (conv_done) begin
         shift_q <= coded;
         result_bit_output <= coded[`SARRD_RES_W-1];
      end else if (shift_edge && out_enabled) begin
         shift_q <= shift_next;
         result_bit_output <= shift_next[`SARRD_RES_W-1];
      end
   end

   // Output enable: off until pins settle, then always in chain mode, gate low in normal mode
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         result_bit_output_oe <= 1'b0;
      end else if (!pins_valid) begin
         result_bit_output_oe <= 1'b0;
      end else if (chain_mode) begin
         result_bit_output_oe <= 1'b1;
      end else begin
         result_bit_output_oe <= ~gate_low;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // AXI4-Lite write channel

   logic [7:0] aw_addr_q;
   logic [31:0] w_data_q;
   logic [3:0] w_strb_q;
   logic aw_have_q;
   logic w_have_q;
   logic wr_fire;
   logic wr_mapped;

   assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;
   assign wr_mapped = (aw_addr_q == `SARRD_OFF_CTRL) ||
      (aw_addr_q == `SARRD_OFF_STATUS) ||
      (aw_addr_q == `SARRD_OFF_SAMPLE) ||
      (aw_addr_q == `SARRD_OFF_RESULT) ||
      (aw_addr_q == `SARRD_OFF_COUNT);

   // Address and data taken in either order, each held once
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         aw_addr_q <= '0;
         w_data_q <= '0;
         w_strb_q <= '0;
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_addr_q <= {s_axi_awaddr[7:2], 2'b00};
            aw_have_q <= 1'b1;
            s_axi_awready <= 1'b0;
         end else if (wr_fire) begin
            aw_have_q <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
            w_have_q <= 1'b1;
            s_axi_wready <= 1'b0;
         end else if (wr_fire) begin
            w_have_q <= 1'b0;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   // Response after both halves arrive
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `SARRD_RESP_OKAY;
      end else if (wr_fire) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wr_mapped ? `SARRD_RESP_OKAY : `SARRD_RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Writable registers with byte strobes
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_q <= `SARRD_CTRL_RESET;
         sample_q <= `SARRD_SAMPLE_RESET;
      end else if (wr_fire) begin
         for (int b = 0; b < 4; b++) begin
            if (w_strb_q[b] && aw_addr_q == `SARRD_OFF_CTRL) begin
               ctrl_q[b*8 +: 8] <= w_data_q[b*8 +: 8];
            end
            if (w_strb_q[b] && b < 2 && aw_addr_q == `SARRD_OFF_SAMPLE) begin
               sample_q[(b%2)*8 +: 8] <= w_data_q[b*8 +: 8];
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // AXI4-Lite read channel

   logic [31:0] rd_word;
   logic rd_mapped;

   // Read multiplexer
   always_comb begin
      rd_word = 32'h00000000;
      rd_mapped = 1'b1;
      case ({s_axi_araddr[7:2], 2'b00})
         `SARRD_OFF_CTRL: begin
            rd_word = ctrl_q;
         end
         `SARRD_OFF_STATUS: begin
            rd_word[`SARRD_ST_BUSY] = busy;
            rd_word[`SARRD_ST_CHAIN] = chain_mode;
            rd_word[`SARRD_ST_SQUEEZE] = squeeze_on;
            rd_word[`SARRD_ST_OUT_EN] = result_bit_output_oe;
         end
         `SARRD_OFF_SAMPLE: begin
            rd_word[`SARRD_RES_W-1:0] = sample_q;
         end
         `SARRD_OFF_RESULT: begin
            rd_word[`SARRD_RES_W-1:0] = result_q;
         end
         `SARRD_OFF_COUNT: begin
            rd_word = count_q;
         end
         default: begin
            rd_mapped = 1'b0;
         end
      endcase
   end

   // One read at a time, answered the cycle after the address
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= `SARRD_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_word;
         s_axi_rresp <= rd_mapped ? `SARRD_RESP_OKAY : `SARRD_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // Address bits outside [7:2] and unused sync outputs
   logic unused_ok;
   assign unused_ok = ^{s_axi_awaddr[31:8], s_axi_awaddr[1:0],
                        s_axi_araddr[31:8], s_axi_araddr[1:0],
                        pins_q.convert_start, pins_q.shift_clock,
                        pins_rise.chain_select,
                        pins_rise.read_enable_or_upstream_input,
                        pins_rise.gain_compression_select};
endmodule : sarrd_top

// ### sim/sarrd_sva.sv
`timescale 1ns/1ps
module sarrd_sva (
   input wire logic aclk, // System clock
   input wire logic aresetn, // Synchronous reset, active low
   input wire sarrd_pkg::sarrd_pins_t pins, // Device pins
   input wire logic busy, // Conversion in progress
   input wire logic result_bit_output, // Serial data out
   input wire logic result_bit_output_oe // Serial output enable
);
   import sarrd_pkg::*;
   logic [4:0] busy_cnt_q;
   ////////////////////////////////////////////////////////////////////////
   // Length of the current busy phase
   always_ff @(posedge aclk) begin
      if (!aresetn || !busy) begin
         busy_cnt_q <= 5'h00;
      end else begin
         busy_cnt_q <= busy_cnt_q + 5'h01;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   property p_start;
      $rose(pins.convert_start) && !busy |-> ##[2:6] busy;
   endproperty
   a_start: assert property (p_start)
      else $error("busy did not follow a start");
   property p_cause;
      $rose(busy) |-> $past(pins.convert_start, 3);
   endproperty
   a_cause: assert property (p_cause)
      else $error("busy rose without a start");
   property p_len;
      $fell(busy) |-> busy_cnt_q >= 5'h0F;
   endproperty
   a_len: assert property (p_len)
      else $error("conversion ended early");
   property p_max;
      busy |-> busy_cnt_q < 5'h10;
   endproperty
   a_max: assert property (p_max)
      else $error("conversion ran too long");
   property p_oe_on;
      (!pins.chain_select && !pins.read_enable_or_upstream_input) [*6]
         |-> result_bit_output_oe;
   endproperty
   a_oe_on: assert property (p_oe_on)
      else $error("output not driven with gate low");
   property p_oe_off;
      (!pins.chain_select && pins.read_enable_or_upstream_input) [*6]
         |-> !result_bit_output_oe;
   endproperty
   a_oe_off: assert property (p_oe_off)
      else $error("output driven with gate high");
   property p_oe_chain;
      pins.chain_select [*6] |-> result_bit_output_oe;
   endproperty
   a_oe_chain: assert property (p_oe_chain)
      else $error("output not driven in chain mode");
   property p_shift;
      $changed(result_bit_output) |-> $past(busy) || $past(busy, 2)
         || $past(pins.shift_clock, 2) || $past(pins.shift_clock, 3)
         || $past(pins.shift_clock, 4) || $past(pins.shift_clock, 5);
   endproperty
   a_shift: assert property (p_shift)
      else $error("output moved without a shift edge");
   property p_hold;
      (!pins.chain_select && pins.read_enable_or_upstream_input) [*6]
         |-> $stable(result_bit_output) || $past(busy);
   endproperty
   a_hold: assert property (p_hold)
      else $error("output shifted while gated off");
   property p_rst_quiet;
      !$past(aresetn, 2) |-> !result_bit_output_oe;
   endproperty
   a_rst_quiet: assert property (p_rst_quiet)
      else $error("output driven straight after reset");
   // Main scenarios reached
   c_conv: cover property ($fell(busy));
   c_norm: cover property (result_bit_output_oe && $rose(pins.shift_clock));
   c_chain: cover property (pins.chain_select && $rose(pins.shift_clock));
endmodule : sarrd_sva

bind sarrd_top sarrd_sva i_sva (.aclk, .aresetn, .pins, .busy,
   .result_bit_output, .result_bit_output_oe);

// ### sim/sarrd_host.sv
`timescale 1ns/1ps
module sarrd_host (
   input wire logic aclk, // System clock
   input wire logic busy, // Conversion in progress
   input wire logic result_bit_output, // Serial data from device
   output sarrd_pkg::sarrd_pins_t pins // Pins toward the device
);
   import sarrd_pkg::*;
   // Idle: gate high, squeeze off, shift clock still
   initial pins = 5'h03;
   ////////////////////////////////////////////////////////////////////////
   // Mode pins, then time for the sync stages
   task automatic mode(input logic ch, gate, sq_off);
      @(posedge aclk);
      pins.chain_select <= ch;
      pins.read_enable_or_upstream_input <= gate;
      pins.gain_compression_select <= sq_off;
      repeat (8) @(posedge aclk);
   endtask : mode
   // Start pulse, then wait out the conversion
   task automatic convert(output logic seen);
      @(posedge aclk);
      pins.convert_start <= 1'b1;
      repeat (6) @(posedge aclk);
      seen = busy;
      pins.convert_start <= 1'b0;
      while (busy) @(posedge aclk);
   endtask : convert
   // Shift n bits; upstream word fed MSB first in chain mode
   task automatic frame(input int n, input logic [15:0] up,
      output logic [31:0] got);
      logic ch;
      ch = pins.chain_select;
      got = '0;
      for (int i = 0; i < n; i++) begin
         if (ch) begin
            pins.read_enable_or_upstream_input <=
               (i < 16) ? up[15-i] : ~up[0];
         end
         repeat (4) @(posedge aclk);
         got = {got[30:0], result_bit_output};
         pins.shift_clock <= 1'b1;
         repeat (4) @(posedge aclk);
         pins.shift_clock <= 1'b0;
      end
   endtask : frame
endmodule : sarrd_host

// ### sim/tb_sar_adc_serial_readout.sv
`timescale 1ns/1ps
`include "sarrd_params.svh"
module tb_sar_adc_serial_readout;
   import sarrd_pkg::*;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   sarrd_pins_t pins;
   logic busy, result_bit_output, result_bit_output_oe;
   logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   logic [15:0] corner [4] = '{16'h0000, 16'hFFFF, 16'h7FFF, 16'h8000};
   int num_errors = 0;
   int comparisons = 0;
   always #10 aclk = ~aclk;
   sarrd_top i_dut (.aclk, .aresetn, .pins, .busy, .result_bit_output,
      .result_bit_output_oe, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready);
   sarrd_host i_host (.aclk, .busy, .result_bit_output, .pins);
   ////////////////////////////////////////////////////////////////////////
   // Expected word: plain, or scaled by the squeeze gain
   function automatic logic [15:0] exp_word(input logic [15:0] s,
      input logic off);
      int p;
      p = $signed(s) * int'(`SARRD_SQUEEZE_GAIN);
      return off ? s : 16'(p >>> 15);
   endfunction : exp_word
   task automatic chk(input logic [31:0] got, exp);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic axw(input logic [31:0] a, d, output logic [1:0] r);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask : axw
   task automatic axr(input logic [31:0] a, output logic [31:0] d,
      output logic [1:0] r);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask : axr
   task automatic wrap_up;
      $display("errors %0d comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : wrap_up
   ////////////////////////////////////////////////////////////////////////
   // Watchdog against a hang
   initial begin
      #400000;
      num_errors++;
      wrap_up();
   end
   // Main sequence
   initial begin
      logic [31:0] rd, got, st;
      logic [1:0] rs;
      logic [15:0] s, u;
      logic sq, seen;
      void'($urandom(3535));
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      // Reset values and an unmapped place
      axr(`SARRD_OFF_CTRL, rd, rs);
      chk(rd, `SARRD_CTRL_RESET);
      axr(`SARRD_OFF_SAMPLE, rd, rs);
      chk(rd, `SARRD_SAMPLE_RESET);
      axr(32'h00000020, rd, rs);
      chk(rs, `SARRD_RESP_SLVERR);
      axw(32'h00000020, 32'h00000001, rs);
      chk(rs, `SARRD_RESP_SLVERR);
      axw(`SARRD_OFF_STATUS, 32'h0000000F, rs);
      chk(rs, `SARRD_RESP_OKAY);
      // Output gate in normal mode
      i_host.mode(1'b0, 1'b1, 1'b1);
      chk(result_bit_output_oe, 1'b0);
      // Normal-mode conversions, corners first
      for (int i = 0; i < 12; i++) begin
         s = (i < 4) ? corner[i] : 16'($urandom);
         sq = (i < 2) ? 1'b1 : 1'($urandom);
         axw(`SARRD_OFF_SAMPLE, {16'h0000, s}, rs);
         i_host.mode(1'b0, 1'b0, sq);
         chk(result_bit_output_oe, 1'b1);
         i_host.convert(seen);
         chk(seen, 1'b1);
         chk(busy, 1'b0);
         i_host.frame(16, 16'h0000, got);
         chk(got, exp_word(s, sq));
         axr(`SARRD_OFF_RESULT, rd, rs);
         chk(rd[15:0], exp_word(s, sq));
         st = 32'h00000000;
         st[`SARRD_ST_OUT_EN] = 1'b1;
         st[`SARRD_ST_SQUEEZE] = ~sq;
         axr(`SARRD_OFF_STATUS, rd, rs);
         chk(rd, st);
      end
      // Chain mode: own word, then the upstream word
      for (int i = 0; i < 3; i++) begin
         s = 16'($urandom);
         u = 16'($urandom);
         axw(`SARRD_OFF_SAMPLE, {16'h0000, s}, rs);
         i_host.mode(1'b1, ~u[15], 1'b1);
         chk(result_bit_output_oe, 1'b1);
         i_host.convert(seen);
         i_host.frame(32, u, got);
         chk(got, {exp_word(s, 1'b1), u});
      end
      axr(`SARRD_OFF_COUNT, rd, rs);
      chk(rd, 32'h0000000F);
      wrap_up();
   end
endmodule : tb_sar_adc_serial_readout
